// [sfm_ctrl_model.sv]
/*
 * Controller model for the signal fault monitor bench: watchdog toggler.
 * Assumes the bench holds run and shares core_clk and resetn.
 */
module sfm_ctrl_model #(
  parameter int HALF = 40
) (
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic run,
  output logic      watchdog_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // watchdog toggler
  logic [15:0] cnt_q;

  // a healthy controller keeps toggling; run low models a hung one
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q       <= 16'h0000;
      watchdog_in <= 1'b0;
    end else if (run) begin
      if (cnt_q == 16'(HALF - 1)) begin
        cnt_q       <= 16'h0000;
        watchdog_in <= ~watchdog_in;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end
endmodule

// [sfm_monitor.sv]
/*
 * Signal fault monitor core: conflict, red fail, watchdog and card checks,
 * output relay and stop timing control, field indicators, register port.
 * Assumes synchronous inputs on core_clk and comparator-level field inputs.
 */
// Operation
// - watchdog fault after 1500/1000 ms without toggle
// - stop release at relay or 250 ms before
// - legacy red fail: ignore <700, trip >1000 ms
// - enhanced red fail: ignore <1200, trip >1500 ms
// - red enable debounced 100 or 400 ms
// - ac valid hysteresis 98/92 or 103/98 V
// - small card: check channels 1 to 16 only
// - small card, activity on 17/18 faults
// - small card shows inhibit pattern on 17/18 while no fault is latched
// - large card checks all eighteen channels
// - incandescent: green/yellow low, red high thresholds
// - led: low for conflicts, high for red fail
// - green or yellow active; conflict if not permissive
// - red fail when monitored channel fully dark
// - relay energized normally, drops on any fault
// - permissive pairs come from card matrix
// - jumpers can reject one card type
// - contactor coil on suppresses red fail checks
// - red enable off suppresses indication checks unless the always-on jumper is set
// - red enable frozen while ac invalid
module sfm_monitor
  import sfm_pkg::*;
#(
  parameter int P_MS_CYCLES = MS_CYCLES
) (
  input  wire logic                      core_clk,
  input  wire logic                      resetn,
  input  wire logic [1:0]                reg_addr,
  input  wire logic [7:0]                reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [7:0]                reg_rdata,
  input  wire sfm_field_s                field,
  input  wire logic [NCH-1:0][NCH-1:0]   perm,
  input  wire logic                      card_present,
  input  wire logic                      card_is_18,
  input  wire sfm_cfg_s                  cfg_in,
  input  wire logic                      red_enable_in,
  input  wire logic                      contactor_coil_input,
  input  wire logic                      watchdog_in,
  input  wire logic [7:0]                ac_volts,
  output logic                           relay_energized,
  output logic                           stop_timing,
  output sfm_flt_s                       fault_ind,
  output logic      [NCH-1:0]            ind_red,
  output logic      [NCH-1:0]            ind_yellow,
  output logic      [NCH-1:0]            ind_green
);

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(P_MS_CYCLES - 1);

  // ==========================================================
  // configuration capture
  sfm_cfg_s cfg_q;
  logic     cfg_done_q;

  // straps are caught after release, never under reset
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_q      <= '0;
      cfg_done_q <= 1'b0;
    end else if (!cfg_done_q) begin
      cfg_q      <= cfg_in;
      cfg_done_q <= 1'b1;
    end
  end

  // ==========================================================
  // millisecond time base
  logic [TICK_W-1:0] tick_cnt_q;
  logic              tick;

  assign tick = (tick_cnt_q == TICK_LAST);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_q <= '0;
    end else if (tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + TICK_W'(1);
    end
  end

  // ==========================================================
  // ac line classification
  logic       ac_valid_q;
  logic [7:0] ac_on_thr;
  logic [7:0] ac_off_thr;

  assign ac_on_thr  = cfg_q.enh_timing ? AC_ENH_ON : AC_LEG_ON;
  assign ac_off_thr = cfg_q.enh_timing ? AC_ENH_OFF : AC_LEG_OFF;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ac_valid_q <= 1'b0;
    end else if (!cfg_done_q) begin
      // thresholds hang on the straps, which are not in yet
      ac_valid_q <= 1'b0;
    end else if (ac_volts > ac_on_thr) begin
      ac_valid_q <= 1'b1;
    end else if (ac_volts < ac_off_thr) begin
      ac_valid_q <= 1'b0;
    end
  end

  // ==========================================================
  // red enable debounce and contactor coil
  logic    ren_acc_q;
  sfm_ms_t ren_cnt_q;
  sfm_ms_t ren_lim;
  logic    coil_q;

  assign ren_lim = cfg_q.enh_timing ? REN_ENH_MS : REN_LEG_MS;

  // counter freezes during a dip so a short outage cannot flip the state
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ren_acc_q <= 1'b0;
      ren_cnt_q <= MS_ZERO;
    end else if (!ac_valid_q) begin
      ren_cnt_q <= ren_cnt_q;
    end else if (red_enable_in == ren_acc_q) begin
      ren_cnt_q <= MS_ZERO;
    end else if (ren_cnt_q >= ren_lim) begin
      ren_acc_q <= red_enable_in;
      ren_cnt_q <= MS_ZERO;
    end else if (tick) begin
      ren_cnt_q <= ren_cnt_q + MS_ONE;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      coil_q <= 1'b0;
    end else if (ac_valid_q) begin
      coil_q <= contactor_coil_input;
    end
  end

  // ==========================================================
  // program card
  logic           card_ok;
  logic           mode18;
  logic [NCH-1:0] mon;

  assign card_ok = card_present &&
                   (card_is_18 ? !cfg_q.reject_large
                               : !cfg_q.reject_small);
  assign mode18  = card_ok && card_is_18;
  assign mon     = {{(NCH-NCH16){mode18}}, {NCH16{1'b1}}};

  // ==========================================================
  // conflict detection
  logic [NCH-1:0] act;
  logic           conflict;
  logic           ch1718;

  assign act    = field.g_lo | field.y_lo;
  assign ch1718 = card_ok && !card_is_18 && |act[NCH-1:NCH16];

  always_comb begin
    conflict = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      for (int j = i + 1; j < NCH; j++) begin
        if (act[i] && act[j] && mon[i] && mon[j] && !perm[i][j]) begin
          conflict = 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // red fail detection
  logic [NCH-1:0] rf_on;
  logic           rf_any;
  sfm_ms_t        rf_cnt_q;
  sfm_ms_t        rf_lim;
  sfm_ms_t        rf_min;
  logic           rf_trip;

  assign rf_on = cfg_q.led_threshold_select
               ? (field.g_hi | field.y_hi | field.r_hi)
               : (field.g_lo | field.y_lo | field.r_hi);
  assign rf_any  = |(~rf_on & mon) && ren_acc_q && !coil_q;
  assign rf_lim  = cfg_q.enh_timing ? RF_ENH_MS : RF_LEG_MS;
  assign rf_min  = cfg_q.enh_timing ? RF_ENH_MIN_MS : RF_LEG_MIN_MS;
  assign rf_trip = rf_cnt_q >= rf_lim;

  // one shared timer: any dark channel keeps it running
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rf_cnt_q <= MS_ZERO;
    end else if (!rf_any) begin
      rf_cnt_q <= MS_ZERO;
    end else if (tick && !rf_trip) begin
      rf_cnt_q <= rf_cnt_q + MS_ONE;
    end
  end

  // ==========================================================
  // watchdog supervision
  logic    wd_prev_q;
  sfm_ms_t wd_cnt_q;
  sfm_ms_t wd_lim;
  logic    wd_expire;

  assign wd_lim    = cfg_q.enh_timing ? WD_ENH_MS : WD_LEG_MS;
  assign wd_expire = wd_cnt_q >= wd_lim;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wd_prev_q <= 1'b0;
      wd_cnt_q  <= MS_ZERO;
    end else begin
      wd_prev_q <= watchdog_in;
      if (watchdog_in != wd_prev_q) begin
        wd_cnt_q <= MS_ZERO;
      end else if (tick && !wd_expire) begin
        wd_cnt_q <= wd_cnt_q + MS_ONE;
      end
    end
  end

  // ==========================================================
  // fault latch
  sfm_flt_s flt_q;
  sfm_flt_s flt_new;
  logic     flt_clr;
  logic     flt_any;

  assign flt_clr = reg_wr && (reg_addr == REG_CTRL) &&
                   reg_wdata[CTRL_RST_BIT];
  assign flt_new.conflict  = conflict || ch1718;
  assign flt_new.red_fail  = rf_trip;
  assign flt_new.watchdog  = wd_expire;
  assign flt_new.card_ajar = !card_ok || ch1718;
  assign flt_any = |flt_q;

  // a fault present in the clear cycle survives the clear
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      flt_q <= '0;
    end else begin
      flt_q <= (flt_clr ? '0 : flt_q) | flt_new;
    end
  end

  // ==========================================================
  // relay and stop timing sequencing
  sfm_state_e state_q;
  logic       relay_q;
  logic       stop_q;
  sfm_ms_t    lead_cnt_q;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q    <= S_FAULT;
      relay_q    <= 1'b0;
      stop_q     <= 1'b1;
      lead_cnt_q <= MS_ZERO;
    end else begin
      case (state_q)
        S_RUN: begin
          if (flt_any) begin
            state_q <= S_FAULT;
            relay_q <= 1'b0;
            stop_q  <= 1'b1;
          end
        end
        S_FAULT: begin
          // a cause seen now only latches next edge, so wait for it too
          if (!flt_any && !(|flt_new) && cfg_done_q) begin
            if (cfg_q.enh_timing) begin
              state_q    <= S_LEAD;
              stop_q     <= 1'b0;
              lead_cnt_q <= MS_ZERO;
            end else begin
              state_q <= S_RUN;
              relay_q <= 1'b1;
              stop_q  <= 1'b0;
            end
          end
        end
        S_LEAD: begin
          if (flt_any) begin
            state_q <= S_FAULT;
            stop_q  <= 1'b1;
          end else if (lead_cnt_q >= STOP_LEAD_MS) begin
            state_q <= S_RUN;
            relay_q <= 1'b1;
          end else if (tick) begin
            lead_cnt_q <= lead_cnt_q + MS_ONE;
          end
        end
        default: begin
          state_q <= S_FAULT;
          relay_q <= 1'b0;
          stop_q  <= 1'b1;
        end
      endcase
    end
  end

  assign relay_energized = relay_q;
  assign stop_timing     = stop_q;
  assign fault_ind       = flt_q;

  // ==========================================================
  // field indicators
  logic [NCH-1:0] ind_r_q;
  logic [NCH-1:0] ind_y_q;
  logic [NCH-1:0] ind_g_q;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ind_r_q <= '0;
      ind_y_q <= '0;
      ind_g_q <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (!mon[i] && !flt_any) begin
          {ind_r_q[i], ind_y_q[i], ind_g_q[i]} <= INHIBIT_RYG;
        end else begin
          ind_r_q[i] <= field.r_hi[i];
          ind_y_q[i] <= field.y_lo[i];
          ind_g_q[i] <= field.g_lo[i];
        end
      end
    end
  end

  assign ind_red    = ind_r_q;
  assign ind_yellow = ind_y_q;
  assign ind_green  = ind_g_q;

  // ==========================================================
  // register port
  logic       ind_chk;
  logic [7:0] rdata_q;
  logic [7:0] rd_mux;

  // gate for indication checks done by the downstream sequence logic
  assign ind_chk = (ren_acc_q || cfg_q.indication_checks_always_on_jumper) && !coil_q;

  always_comb begin
    case (reg_addr)
      REG_STAT: rd_mux = {ind_chk, mode18, ren_acc_q, ac_valid_q, flt_q};
      REG_CFG:  rd_mux = {1'b0, state_q, card_ok, coil_q,
                          cfg_q.indication_checks_always_on_jumper, cfg_q.led_threshold_select,
                          cfg_q.enh_timing};
      default:  rd_mux = RD_ZERO;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= RD_ZERO;
    end else begin
      rdata_q <= reg_rd ? rd_mux : RD_ZERO;
    end
  end

  assign reg_rdata = rdata_q;

  // ==========================================================
  // assertions
  AST_WD_FAULT: assert property (@(posedge core_clk) disable iff (!resetn)
    wd_expire |=> flt_q.watchdog)
    else $error("watchdog expiry did not latch a fault");

  AST_STOP_LEGACY: assert property (@(posedge core_clk) disable iff (!resetn)
    !cfg_q.enh_timing && $rose(relay_q) |-> $fell(stop_q))
    else $error("stop timing not released with relay");

  AST_STOP_LEAD: assert property (@(posedge core_clk) disable iff (!resetn)
    cfg_q.enh_timing && $rose(relay_q) |->
      !$past(stop_q) && $past(lead_cnt_q) >= STOP_LEAD_MS)
    else $error("stop timing lead too short");

  AST_RF_IGNORE: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(flt_q.red_fail) |-> $past(rf_cnt_q) >= rf_min)
    else $error("red fail tripped below ignore time");

  AST_RF_TRIP: assert property (@(posedge core_clk) disable iff (!resetn)
    rf_trip |=> flt_q.red_fail)
    else $error("red fail not latched at trip time");

  AST_REN_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
    $changed(ren_acc_q) |->
      $past(ac_valid_q) && $past(ren_cnt_q) >= ren_lim)
    else $error("red enable changed before debounce");

  AST_AC_HYST: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(ac_valid_q) |-> $past(ac_volts) > ac_on_thr)
    else $error("ac valid below on threshold");

  AST_CH1718: assert property (@(posedge core_clk) disable iff (!resetn)
    ch1718 |=> flt_q.conflict && flt_q.card_ajar)
    else $error("channel 17/18 activity not faulted");

  AST_CARD: assert property (@(posedge core_clk) disable iff (!resetn)
    !card_ok |=> flt_q.card_ajar && !relay_q)
    else $error("unacceptable card not faulted");

  AST_RELAY: assert property (@(posedge core_clk) disable iff (!resetn)
    flt_any |=> !relay_q)
    else $error("relay energized during fault");

endmodule

// [sfm_pkg.sv]
/*
 * Shared constants, types and register map of the signal fault monitor.
 * Assumes a 50 MHz core clock and field inputs already thresholded by the
 * analogue front end into low (25/15 V) and high (70/50 V) comparators.
 */
package sfm_pkg;

  // ==========================================================
  // clock and time base
  localparam int CLK_HZ    = 50_000_000;
  localparam int MS_PER_S  = 1000;
  localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam int TICK_W    = 16;

  // ==========================================================
  // channels
  localparam int NCH   = 18;
  localparam int NCH16 = 16;

  // ==========================================================
  // millisecond timings
  localparam int MSW = 11;
  typedef logic [MSW-1:0] sfm_ms_t;
  localparam sfm_ms_t WD_LEG_MS     = 11'h5dc; // 1500 ms
  localparam sfm_ms_t WD_ENH_MS     = 11'h3e8; // 1000 ms
  localparam sfm_ms_t STOP_LEAD_MS  = 11'h0fa; // 250 ms
  localparam sfm_ms_t RF_LEG_MIN_MS = 11'h2bc; // 700 ms
  localparam sfm_ms_t RF_LEG_MS     = 11'h3e8; // 1000 ms
  localparam sfm_ms_t RF_ENH_MIN_MS = 11'h4b0; // 1200 ms
  localparam sfm_ms_t RF_ENH_MS     = 11'h5dc; // 1500 ms
  localparam sfm_ms_t REN_LEG_MS    = 11'h064; // 100 ms
  localparam sfm_ms_t REN_ENH_MS    = 11'h190; // 400 ms
  localparam sfm_ms_t MS_ONE        = 11'h001;
  localparam sfm_ms_t MS_ZERO       = 11'h000;

  // ==========================================================
  // ac line thresholds, volts rms
  localparam logic [7:0] AC_LEG_ON  = 8'h62; // 98 V
  localparam logic [7:0] AC_LEG_OFF = 8'h5c; // 92 V
  localparam logic [7:0] AC_ENH_ON  = 8'h67; // 103 V
  localparam logic [7:0] AC_ENH_OFF = 8'h62; // 98 V

  // ==========================================================
  // register map
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_STAT = 2'h1;
  localparam logic [1:0] REG_CFG  = 2'h2;
  localparam int CTRL_RST_BIT = 0;
  localparam logic [7:0] RD_ZERO = 8'h00;

  // red, yellow, green lamp pattern for an inhibited channel
  localparam logic [2:0] INHIBIT_RYG = 3'h7;

  // ==========================================================
  // types
  typedef struct packed {
    logic [NCH-1:0] g_lo;
    logic [NCH-1:0] y_lo;
    logic [NCH-1:0] r_lo;
    logic [NCH-1:0] g_hi;
    logic [NCH-1:0] y_hi;
    logic [NCH-1:0] r_hi;
  } sfm_field_s;

  typedef struct packed {
    logic enh_timing;
    logic led_threshold_select;
    logic reject_small;
    logic reject_large;
    logic indication_checks_always_on_jumper;
  } sfm_cfg_s;

  typedef struct packed {
    logic card_ajar;
    logic watchdog;
    logic red_fail;
    logic conflict;
  } sfm_flt_s;

  typedef enum logic [1:0] {
    S_RUN   = 2'b00,
    S_FAULT = 2'b01,
    S_LEAD  = 2'b10
  } sfm_state_e;

endpackage

// [tb_top.sv]
/*
 * Self-checking bench of the signal fault monitor: conflict, red fail,
 * watchdog, red enable, line voltage, card modes and stop timing.
 * Assumes a 4 cycle millisecond tick and the controller model.
 */
module tb_top import sfm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // signals
  localparam int MSC = 4; // short ms tick keeps the run small
  logic                    core_clk, resetn, reg_wr, reg_rd, wd_run;
  logic [1:0]              reg_addr;
  logic [7:0]              reg_wdata, reg_rdata, ac_volts;
  sfm_field_s              field;
  logic [NCH-1:0][NCH-1:0] perm;
  logic                    card_present, card_is_18;
  sfm_cfg_s                cfg_in;
  logic                    red_enable_in, contactor_coil_input, watchdog_in;
  logic                    relay_energized, stop_timing;
  sfm_flt_s                fault_ind;
  logic [NCH-1:0]          ind_red, ind_yellow, ind_green;
  int                      fail_count, samples_checked, seed, a, b, c;
  logic [15:0]             exp_q[$];
  logic                    rd_pend;

  sfm_monitor #(.P_MS_CYCLES(MSC)) u_sfm_monitor (
    .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .field(field), .perm(perm),
    .card_present(card_present), .card_is_18(card_is_18),
    .cfg_in(cfg_in), .red_enable_in(red_enable_in),
    .contactor_coil_input(contactor_coil_input),
    .watchdog_in(watchdog_in), .ac_volts(ac_volts),
    .relay_energized(relay_energized), .stop_timing(stop_timing),
    .fault_ind(fault_ind), .ind_red(ind_red), .ind_yellow(ind_yellow),
    .ind_green(ind_green));

  sfm_ctrl_model u_sfm_ctrl_model (
    .core_clk(core_clk), .resetn(resetn), .run(wd_run),
    .watchdog_in(watchdog_in));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // ==========================================================
  // compare and bus tasks
  task automatic cmp_port(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_reg(input logic [7:0] got, input logic [15:0] me);
    samples_checked++;
    if ((got & me[15:8]) !== (me[7:0] & me[15:8])) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, me[7:0]);
    end
  endtask

  // read data stand only in the cycle after the strobe
  always @(negedge core_clk) begin
    if (rd_pend) begin
      cmp_reg(reg_rdata, exp_q.pop_front());
    end
    rd_pend = reg_rd;
  end

  task automatic wr(input logic [1:0] ad, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= ad;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] ad, input logic [7:0] m,
                    input logic [7:0] e);
    exp_q.push_back({m, e});
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= ad;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  task automatic do_reset(input sfm_cfg_s cf, input logic big);
    @(posedge core_clk);
    resetn     <= 1'b0;
    cfg_in     <= cf;
    card_is_18 <= big;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
  endtask

  // legacy release: relay and stop timing must flip on the same edge
  task automatic clear_legacy();
    wr(REG_CTRL, 8'h01);
    repeat (8) begin
      @(negedge core_clk);
      cmp_port({7'h00, relay_energized ^ stop_timing}, 8'h01);
    end
    cmp_port({7'h00, relay_energized}, 8'h01);
  endtask

  task automatic print_verdict();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge core_clk);
    fail_count++;
    print_verdict();
  end

  // ==========================================================
  // main sequence
  initial begin
    fail_count = 0;
    samples_checked = 0;
    rd_pend = 1'b0;
    seed = 32'h2296388a;
    resetn = 1'b0;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    field = '0;
    field.r_lo = '1;
    field.r_hi = '1;
    perm = '0;
    {card_present, card_is_18, red_enable_in, wd_run} = 4'hf;
    cfg_in = '0;
    contactor_coil_input = 1'b0;
    ac_volts = 8'h78;
    a = {$random(seed)} % 17;
    b = a + 1 + {$random(seed)} % (17 - a);
    c = {$random(seed)} % 18;
    do_reset(5'h00, 1'b1);
    settle(500);
    cmp_port({7'h00, relay_energized}, 8'h01);
    rd(REG_STAT, 8'hff, 8'hf0);
    rd(REG_CFG, 8'hff, 8'h10);
    rd(2'h3, 8'hff, 8'h00);
    @(posedge core_clk);
    field.g_lo[a] <= 1'b1;
    field.y_lo[b] <= 1'b1;
    settle(3);
    cmp_port({4'h0, fault_ind}, 8'h01);
    cmp_port({6'h00, relay_energized, stop_timing}, 8'h01);
    rd(REG_STAT, 8'h0f, 8'h01);
    @(posedge core_clk);
    field.g_lo[a] <= 1'b0;
    field.y_lo[b] <= 1'b0;
    clear_legacy();
    @(posedge core_clk);
    perm[a][b] <= 1'b1;
    perm[b][a] <= 1'b1;
    field.g_lo[a] <= 1'b1;
    field.y_lo[b] <= 1'b1;
    settle(20);
    cmp_port({4'h0, fault_ind}, 8'h00);
    @(posedge core_clk);
    field.g_lo[a] <= 1'b0;
    field.y_lo[b] <= 1'b0;
    field.r_lo[c] <= 1'b0;
    field.r_hi[c] <= 1'b0;
    settle(675 * MSC);
    cmp_port({4'h0, fault_ind}, 8'h00);
    settle(350 * MSC);
    cmp_port({4'h0, fault_ind}, 8'h02);
    @(posedge core_clk);
    contactor_coil_input <= 1'b1;
    settle(20);
    clear_legacy();
    settle(1100 * MSC);
    cmp_port({4'h0, fault_ind}, 8'h00);
    @(posedge core_clk);
    contactor_coil_input <= 1'b0;
    field.r_lo[c] <= 1'b1;
    field.r_hi[c] <= 1'b1;
    wd_run <= 1'b0;
    settle(1475 * MSC);
    cmp_port({4'h0, fault_ind}, 8'h00);
    settle(50 * MSC);
    cmp_port({4'h0, fault_ind}, 8'h04);
    @(posedge core_clk);
    wd_run <= 1'b1;
    settle(100);
    clear_legacy();
    @(posedge core_clk);
    red_enable_in <= 1'b0;
    settle(90 * MSC);
    rd(REG_STAT, 8'h20, 8'h20);
    settle(20 * MSC);
    rd(REG_STAT, 8'hf0, 8'h50);
    @(posedge core_clk);
    ac_volts <= 8'h50;
    settle(20);
    rd(REG_STAT, 8'h10, 8'h00);
    @(posedge core_clk);
    red_enable_in <= 1'b1;
    ac_volts <= 8'h5f;
    settle(200 * MSC);
    rd(REG_STAT, 8'h30, 8'h00);
    @(posedge core_clk);
    ac_volts <= 8'h64;
    settle(20);
    rd(REG_STAT, 8'h10, 8'h10);
    // small card refused by its jumper
    do_reset(5'h04, 1'b0);
    settle(20);
    cmp_port({4'h0, fault_ind} & 8'h08, 8'h08);
    cmp_port({7'h00, relay_energized}, 8'h00);
    // enhanced timing, small card allowed
    do_reset(5'h1b, 1'b0);
    settle(1300);
    cmp_port({7'h00, relay_energized}, 8'h01);
    cmp_port({2'h0, ind_red[17:16], ind_yellow[17:16],
              ind_green[17:16]}, 8'h3f);
    rd(REG_STAT, 8'hc0, 8'h80);
    rd(REG_CFG, 8'h07, 8'h07);
    @(posedge core_clk);
    field.g_lo[16] <= 1'b1;
    field.g_hi[16] <= 1'b1;
    settle(3);
    cmp_port({4'h0, fault_ind}, 8'h09);
    @(posedge core_clk);
    field.g_lo[16] <= 1'b0;
    field.g_hi[16] <= 1'b0;
    wr(REG_CTRL, 8'h01);
    settle(3);
    cmp_port({6'h00, relay_energized, stop_timing}, 8'h00);
    settle(240 * MSC);
    cmp_port({7'h00, relay_energized}, 8'h00);
    settle(20 * MSC);
    cmp_port({7'h00, relay_energized}, 8'h01);
    print_verdict();
  end
endmodule
